// ### bench/docf_host.sv
// Purpose: AXI4-Lite host that programs the block
// Assumes: One access at a time, called from the bench
// Notes: Released address and data lines show inverted values
`timescale 1ns/1ns
`default_nettype none
module docf_host
  import docf_pkg::*;
(
  input wire logic clk_i,
  output logic [7:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  output logic [7:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk_i);
    awaddr_o <= a;
    awvalid_o <= 1'b1;
    wdata_o <= d;
    wstrb_o <= 4'hf;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    while (!done) begin
      @(posedge clk_i);
      if (awvalid_o && awready_i) begin
        awvalid_o <= 1'b0;
        awaddr_o <= ~a;
      end
      if (wvalid_o && wready_i) begin
        wvalid_o <= 1'b0;
        wdata_o <= ~d;
      end
      if (bvalid_i) begin
        r = bresp_i;
        bready_o <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    while (!done) begin
      @(posedge clk_i);
      if (arvalid_o && arready_i) begin
        arvalid_o <= 1'b0;
        araddr_o <= ~a;
      end
      if (rvalid_i) begin
        d = rdata_i;
        r = rresp_i;
        rready_o <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
endmodule
`default_nettype wire

// ### bench/docf_top_props.sv
// Purpose: Port checks for docf_top
// Assumes: One clock, sync reset
// Notes: Bound to every docf_top
`timescale 1ns/1ns
`default_nettype none
module docf_top_props
  import docf_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic [1:0] S_AXI_RRESP_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic [7:0] DIE_TEMP_I,
  input wire logic ALARM_N_O,
  input wire logic ALARM_N_OE_N_O,
  input wire logic [NUM_CH-1:0] CHAN_SHUTDOWN_O,
  input wire logic [NUM_CH*11-1:0] CHAN_FS_MA_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  wire aw_hs = S_AXI_AWVALID_I && S_AXI_AWREADY_O;
  wire w_hs = S_AXI_WVALID_I && S_AXI_WREADY_O;
  wire ar_hs = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  logic [3:0] wr_age_q;
  logic [3:0] rd_age_q;
  logic [3:0] hot_age_q;
  ////////////////////////////////////////////////////////////
  // Cycles since a write, status read, or hot reading
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I || aw_hs) wr_age_q <= 4'h0;
    else if (wr_age_q != 4'hf) wr_age_q <= wr_age_q + 4'h1;
  end
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) rd_age_q <= 4'hf;
    else if (ar_hs && S_AXI_ARADDR_I == OFS_STATUS) rd_age_q <= 4'h0;
    else if (rd_age_q != 4'hf) rd_age_q <= rd_age_q + 4'h1;
  end
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) hot_age_q <= 4'hf;
    else if (DIE_TEMP_I >= TEMP_OVER_C) hot_age_q <= 4'h0;
    else if (hot_age_q != 4'hf) hot_age_q <= hot_age_q + 4'h1;
  end
  ////////////////////////////////////////////////////////////
  a_reset_idle: assert property ($fell(SYS_RST_I) |-> ALARM_N_O && !ALARM_N_OE_N_O
    && &CHAN_SHUTDOWN_O && !S_AXI_BVALID_O && !S_AXI_RVALID_O)
    else $error("outputs not idle after reset");
  a_b_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
    else $error("write response dropped");
  a_r_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
    else $error("read data dropped");
  a_b_answer: assert property (aw_hs && w_hs |-> ##2 S_AXI_BVALID_O)
    else $error("no write response");
  a_r_answer: assert property (ar_hs |=> S_AXI_RVALID_O)
    else $error("no read response");
  a_no_new_aw: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
    else $error("write taken while response pending");
  a_unmapped_err: assert property (ar_hs && S_AXI_ARADDR_I > 8'h57 |=> S_AXI_RRESP_O == 2'h2
    && S_AXI_RDATA_O == 32'h0)
    else $error("unmapped read not refused");
  a_alarm_drive: assert property (!ALARM_N_O |-> !ALARM_N_OE_N_O)
    else $error("active alarm not driven");
  a_alarm_release: assert property ($rose(ALARM_N_O) |-> wr_age_q <= 4'h5 || rd_age_q <= 4'h3)
    else $error("alarm released without cause");
  a_shdn_cause: assert property ($changed(CHAN_SHUTDOWN_O) |-> wr_age_q <= 4'h5 || hot_age_q <= 4'h5)
    else $error("shutdown changed without cause");
  a_fs_cause: assert property ($changed(CHAN_FS_MA_O) |-> wr_age_q <= 4'h5)
    else $error("full scale changed without write");
  c_alarm: cover property ($fell(ALARM_N_O));
  c_status: cover property (ar_hs && S_AXI_ARADDR_I == OFS_STATUS);
  c_thermal: cover property (&CHAN_SHUTDOWN_O && hot_age_q == 4'h0);
  c_err: cover property (S_AXI_BVALID_O && S_AXI_BRESP_O == 2'h2);
endmodule
bind docf_top docf_top_props i_docf_top_props (.CORE_CLK_I, .SYS_RST_I, .S_AXI_AWVALID_I, .S_AXI_AWREADY_O,
  .S_AXI_WVALID_I, .S_AXI_WREADY_O, .S_AXI_BRESP_O, .S_AXI_BVALID_O, .S_AXI_BREADY_I, .S_AXI_ARADDR_I,
  .S_AXI_ARVALID_I, .S_AXI_ARREADY_O, .S_AXI_RDATA_O, .S_AXI_RRESP_O, .S_AXI_RVALID_O, .S_AXI_RREADY_I,
  .DIE_TEMP_I, .ALARM_N_O, .ALARM_N_OE_N_O, .CHAN_SHUTDOWN_O, .CHAN_FS_MA_O);
`default_nettype wire

// ### bench/docf_top_test.sv
// Purpose: Register-level tests of docf_top
// Assumes: Host model drives the register bus
// Notes: Die temperature driven here
`timescale 1ns/1ns
`default_nettype none
module docf_top_test;
  import docf_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] temp = 8'd25;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, alarm_n, oe_n;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [5:0] shdn;
  logic [65:0] fs;
  logic [23:0] damp;
  int errors = 0;
  int n_tests = 0;
  int dc [6] = '{0, 5, 6, 7, 8, 9};
  // Channel, mode, trim, nominal mA, scaled
  int tb [12][5] = '{'{0, 1, 5, 60, 0}, '{0, 2, 5, 300, 0}, '{0, 0, 63, 300, 1}, '{1, 1, 0, 140, 1},
    '{1, 2, 10, 140, 1}, '{1, 3, 1, 250, 1}, '{2, 0, 13, 55, 1}, '{2, 1, 0, 150, 1}, '{2, 2, 0, 0, 1},
    '{3, 1, 63, 100, 1}, '{4, 0, 32, 45, 1}, '{5, 3, 0, 0, 1}};
  always #4 clk = ~clk;
  docf_top i_docf_top (.CORE_CLK_I(clk), .SYS_RST_I(rst), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .DIE_TEMP_I(temp),
    .ALARM_N_O(alarm_n), .ALARM_N_OE_N_O(oe_n), .CHAN_SHUTDOWN_O(shdn), .CHAN_FS_MA_O(fs), .CHAN_DAMP_O(damp));
  docf_host i_docf_host (.clk_i(clk), .awaddr_o(awaddr), .awvalid_o(awvalid), .awready_i(awready),
    .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid),
    .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
    .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] v);
    i_docf_host.wr(a, v, rs);
    cyc(3);
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
    i_docf_host.rd(a, d, rs);
    chk(n, d, e);
    chk(n, rs, 32'h0);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////
  initial begin
    cyc(3);
    rst <= 1'b0;
    cyc(3);
    chk("shdn", shdn, 32'h3f);
    chk("pin", {oe_n, alarm_n}, 32'h1);
    for (int c = 0; c < NUM_CH; c++) begin
      chk("fs rst", fs[c*11 +: 11], c == 0 ? 300 : c == 1 ? 0 : c == 2 ? 55 : 45);
    end
    rc("chan cfg", OFS_CHAN_CFG, 32'h3f);
    rc("alarm cfg", OFS_ALARM_CFG, 32'h0);
    rc("status", OFS_STATUS, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      w(OFS_RANGE_BASE + 8'(4 * tb[i][0]), 32'(tb[i][2] * 4 + tb[i][1]));
      chk("fs", fs[tb[i][0]*11 +: 11], tb[i][4] ? tb[i][3] * (128 - tb[i][2]) / 128 : tb[i][3]);
    end
    for (int i = 0; i < NUM_CH; i++) begin
      w(OFS_DAMP_BASE + 8'(4 * i), dc[i]);
      chk("damp", damp[i*4 +: 4], dc[i]);
    end
    w(OFS_DAMP_BASE, 32'h3);
    rc("valid", OFS_CHAN_STATE, 32'hf9b);
    $display("test decode done");
    temp <= 8'd124;
    cyc(4);
    chk("alarm 124", alarm_n, 32'h1);
    temp <= 8'd125;
    cyc(4);
    chk("alarm 125", alarm_n, 32'h0);
    rc("status warn", OFS_STATUS, 32'h2);
    cyc(2);
    chk("alarm rel", alarm_n, 32'h1);
    rc("status hot", OFS_STATUS, 32'h2);
    temp <= 8'd145;
    cyc(4);
    chk("alarm 145", alarm_n, 32'h0);
    rc("status over", OFS_STATUS, 32'h6);
    temp <= 8'd119;
    cyc(3);
    rc("status cool", OFS_STATUS, 32'h0);
    cyc(2);
    chk("alarm cool", alarm_n, 32'h1);
    $display("test alarm done");
    w(OFS_ALARM_CFG, 32'h18);
    temp <= 8'd145;
    cyc(4);
    chk("masked", alarm_n, 32'h1);
    rc("status masked", OFS_STATUS, 32'h6);
    temp <= 8'd100;
    w(OFS_ALARM_CFG, 32'h1);
    chk("od idle", {oe_n, alarm_n}, 32'h3);
    temp <= 8'd125;
    cyc(4);
    chk("od act", {oe_n, alarm_n}, 32'h0);
    rc("status od", OFS_STATUS, 32'h2);
    cyc(2);
    chk("od rel", {oe_n, alarm_n}, 32'h3);
    temp <= 8'd100;
    $display("test mask done");
    w(OFS_CHAN_CFG, 32'h0);
    chk("shdn off", shdn, 32'h0);
    w(OFS_ALARM_CFG, 32'h2);
    temp <= 8'd145;
    cyc(4);
    chk("thermal", shdn, 32'h3f);
    temp <= 8'd100;
    cyc(3);
    rc("status sd", OFS_STATUS, 32'h8);
    rc("temp", OFS_TEMP, 32'd100);
    w(OFS_CHAN_CFG, 32'h0);
    chk("sd held", shdn, 32'h3f);
    $display("test thermal done");
    w(OFS_SWRST, 32'h1);
    rc("one bit", OFS_ALARM_CFG, 32'h2);
    w(OFS_SWRST, 32'h81);
    rc("swrst", OFS_SWRST, 32'h0);
    rc("cfg rst", OFS_ALARM_CFG, 32'h0);
    rc("status rst", OFS_STATUS, 32'h0);
    chk("fs rst", fs[22 +: 11], 32'd55);
    chk("shdn rst", shdn, 32'h3f);
    // Past one background check period: no false failure
    cyc(1300);
    rc("status crc", OFS_STATUS, 32'h0);
    chk("alarm crc", alarm_n, 32'h1);
    i_docf_host.wr(8'h80, 32'h1, rs);
    chk("wr err", rs, 32'h2);
    i_docf_host.rd(8'h80, d, rs);
    chk("rd err", rs, 32'h2);
    chk("rd err data", d, 32'h0);
    $display("test soft reset done");
    cyc(2);
    complete_run();
  end
endmodule
`default_nettype wire

// ### verilog/docf_chan_decode.sv
// Purpose: Per-channel decode of range mode, damping code and trim
// Assumes: Channel index is a constant parameter
// Notes: Full scale in whole mA, rounded down
`timescale 1ns/1ns
`default_nettype none
module docf_chan_decode
  import docf_pkg::*;
#(
  parameter int CH = 0
) (
  input wire docf_range_t range_i,
  input wire logic [DAMP_W-1:0] damp_i,
  output docf_chan_out_t dec_o,
  output logic damp_ok_o
);
  logic [8:0] nom;
  logic src_only;
  logic mode_ok;
  logic [15:0] prod;

  always_comb begin
    nom = 9'd0;
    src_only = 1'b1;
    mode_ok = 1'b1;
    case (CH)
      0: begin
        case (range_i.mode)
          MODE_C0_SRC300: nom = 9'd300;
          MODE_C0_SNK60: begin
            nom = 9'd60;
            src_only = 1'b0;
          end
          MODE_C0_BIPOLAR: begin
            nom = 9'd300;
            src_only = 1'b0;
          end
          default: mode_ok = 1'b0;
        endcase
      end
      1: begin
        case (range_i.mode)
          MODE_C1_140_LOWHR: nom = 9'd140;
          MODE_C1_140_LOWN: nom = 9'd140;
          MODE_C1_250: nom = 9'd250;
          default: mode_ok = 1'b0;
        endcase
      end
      2: begin
        case (range_i.mode)
          MODE_C2_55: nom = 9'd55;
          MODE_C2_150: nom = 9'd150;
          default: mode_ok = 1'b0;
        endcase
      end
      default: begin
        case (range_i.mode)
          MODE_C345_45: nom = 9'd45;
          MODE_C345_100: nom = 9'd100;
          default: mode_ok = 1'b0;
        endcase
      end
    endcase
  end

  // Scale sourcing-only ranges by (128 - x) / 128, others keep nom
  assign prod = src_only ? 16'(nom) * (16'(TRIM_DENOM) - 16'(range_i.trim)) : {nom, 7'h00};

  always_comb begin
    dec_o.fs_ma = prod[15:5] >> 2;
    dec_o.sourcing_only = src_only;
    dec_o.valid = mode_ok;
  end

  assign damp_ok_o = (damp_i == DAMP_60R) || (damp_i >= DAMP_5K6 && damp_i <= DAMP_104K);
endmodule
`default_nettype wire

// ### verilog/docf_crc_scan.sv
// Purpose: Periodic background CRC over the configuration image
// Assumes: Reference is latched when software writes configuration
// Notes: Pulses fail_o for one cycle on mismatch
`timescale 1ns/1ns
`default_nettype none
module docf_crc_scan
  import docf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [63:0] image_i,
  input wire logic reload_i,
  output logic fail_o
);
  logic [15:0] ref_q;
  logic [15:0] timer_q;
  logic [7:0] crc;
  logic load_q;

  function automatic logic [7:0] crc8(input logic [63:0] d);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 63; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction

  assign crc = crc8(image_i);

  // Reference taken once the written value has landed
  always_ff @(posedge clk_i) begin
    load_q <= rst_i || reload_i;
  end

  always_ff @(posedge clk_i) begin
    if (load_q) begin
      ref_q <= {8'h00, crc};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || reload_i || load_q) begin
      timer_q <= 16'h0000;
    end else if (timer_q == 16'(CRC_PERIOD_CYC - 1)) begin
      timer_q <= 16'h0000;
    end else begin
      timer_q <= timer_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fail_o <= 1'b0;
    end else begin
      fail_o <= !reload_i && (timer_q == 16'(CRC_PERIOD_CYC - 1)) && (crc != ref_q[7:0]);
    end
  end
endmodule
`default_nettype wire

// ### verilog/docf_pkg.sv
// Purpose: Shared constants and types for output config and fault alarm
// Assumes: 32-bit AXI4-Lite register access, one word per register
// Notes: Offsets are byte addresses of aligned words
package docf_pkg;
  localparam int NUM_CH = 6;
  // Register byte offsets
  localparam logic [7:0] OFS_RANGE_BASE = 8'h00;
  localparam logic [7:0] OFS_DAMP_BASE = 8'h20;
  localparam logic [7:0] OFS_CHAN_CFG = 8'h40;
  localparam logic [7:0] OFS_ALARM_CFG = 8'h44;
  localparam logic [7:0] OFS_STATUS = 8'h48;
  localparam logic [7:0] OFS_SWRST = 8'h4c;
  localparam logic [7:0] OFS_TEMP = 8'h50;
  localparam logic [7:0] OFS_CHAN_STATE = 8'h54;
  // Range register fields
  localparam int RNG_MODE_LSB = 0;
  localparam int RNG_MODE_W = 2;
  localparam int RNG_TRIM_LSB = 2;
  localparam int RNG_TRIM_W = 6;
  localparam int DAMP_W = 4;
  // Alarm configuration bits
  localparam int ACFG_OPEN_DRAIN = 0;
  localparam int ACFG_THERM_SD_EN = 1;
  localparam int ACFG_CRC_MASK = 2;
  localparam int ACFG_OT_MASK = 3;
  localparam int ACFG_TW_MASK = 4;
  // Status bits
  localparam int STAT_CRC = 0;
  localparam int STAT_TW = 1;
  localparam int STAT_OT = 2;
  // Soft reset bits
  localparam int SWRST_LOWER = 0;
  localparam int SWRST_UPPER = 7;
  // Reset values
  localparam logic [7:0] RANGE_RST = 8'h00;
  localparam logic [3:0] DAMP_RST = 4'h0;
  localparam logic [5:0] SHDN_RST = 6'h3f;
  localparam logic [4:0] ACFG_RST = 5'h00;
  // Range mode codes
  localparam logic [1:0] MODE_C0_SRC300 = 2'h0;
  localparam logic [1:0] MODE_C0_SNK60 = 2'h1;
  localparam logic [1:0] MODE_C0_BIPOLAR = 2'h2;
  localparam logic [1:0] MODE_C1_140_LOWHR = 2'h1;
  localparam logic [1:0] MODE_C1_140_LOWN = 2'h2;
  localparam logic [1:0] MODE_C1_250 = 2'h3;
  localparam logic [1:0] MODE_C2_55 = 2'h0;
  localparam logic [1:0] MODE_C2_150 = 2'h1;
  localparam logic [1:0] MODE_C345_45 = 2'h0;
  localparam logic [1:0] MODE_C345_100 = 2'h1;
  // Damping resistor codes
  localparam logic [3:0] DAMP_60R = 4'h0;
  localparam logic [3:0] DAMP_5K6 = 4'h5;
  localparam logic [3:0] DAMP_104K = 4'h9;
  localparam logic [7:0] TRIM_DENOM = 8'h80;
  // Temperature thresholds, degrees C on an 8-bit die reading
  localparam logic [7:0] TEMP_WARN_C = 8'd125;
  localparam logic [7:0] TEMP_OVER_C = 8'd145;
  localparam logic [7:0] TEMP_CLEAR_C = 8'd120;
  // Background check period
  localparam int CRC_PERIOD_US = 10;
  localparam int CLK_MHZ = 125;
  localparam int CRC_PERIOD_CYC = CRC_PERIOD_US * CLK_MHZ;

  typedef enum logic [2:0] {
    RSEL_RESERVED, RSEL_SRC, RSEL_SNK, RSEL_BIPOLAR
  } docf_kind_t;

  typedef struct packed {
    logic [RNG_TRIM_W-1:0] trim;
    logic [RNG_MODE_W-1:0] mode;
  } docf_range_t;

  typedef struct packed {
    logic [10:0] fs_ma;       // Effective full scale, mA
    logic sourcing_only;
    logic valid;              // Code not reserved
  } docf_chan_out_t;
endpackage

// ### verilog/docf_top.sv
// Purpose: Output configuration and fault alarm control, AXI4-Lite slave
// Assumes: Die temperature arrives as an 8-bit degrees C reading
// Notes: Alarm pin is active low, optionally open drain
`timescale 1ns/1ns
`default_nettype none
module docf_top
  import docf_pkg::*;
(
  input wire logic CORE_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic [7:0] DIE_TEMP_I,
  output logic ALARM_N_O,
  output logic ALARM_N_OE_N_O,
  output logic [NUM_CH-1:0] CHAN_SHUTDOWN_O,
  output logic [NUM_CH*11-1:0] CHAN_FS_MA_O,
  output logic [NUM_CH*DAMP_W-1:0] CHAN_DAMP_O
);
  docf_range_t range_q [NUM_CH];
  logic [DAMP_W-1:0] damp_q [NUM_CH];
  logic [NUM_CH-1:0] shdn_q;
  logic [4:0] acfg_q;
  logic stat_crc_q, stat_tw_q, stat_ot_q;
  logic pend_crc_q, pend_tw_q, pend_ot_q;
  logic therm_sd_q;
  logic tw_prev_q, ot_prev_q;
  logic aw_got_q, w_got_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic soft_rst;
  logic cfg_rst;
  logic wr_fire, rd_fire;
  logic [7:0] wa;
  logic wr_ok, rd_ok;
  logic status_read;
  logic crc_fail;
  logic alarm_n_d;
  logic [31:0] rd_val;
  logic tw_hot, ot_hot, cool;
  docf_chan_out_t dec [NUM_CH];
  logic [NUM_CH-1:0] damp_ok;
  logic [NUM_CH-1:0] mode_ok;
  logic [63:0] image;

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path
  assign S_AXI_AWREADY_O = !aw_got_q && !S_AXI_BVALID_O;
  assign S_AXI_WREADY_O = !w_got_q && !S_AXI_BVALID_O;
  assign wr_fire = aw_got_q && w_got_q && !S_AXI_BVALID_O;
  assign wa = aw_addr_q;

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_got_q <= 1'b1;
        aw_addr_q <= S_AXI_AWADDR_I;
      end else if (wr_fire) begin
        aw_got_q <= 1'b0;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_got_q <= 1'b1;
        w_data_q <= S_AXI_WDATA_I;
        w_strb_q <= S_AXI_WSTRB_I;
      end else if (wr_fire) begin
        w_got_q <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_ok = 1'b0;
    if (wa[1:0] == 2'b00) begin
      if (wa < OFS_RANGE_BASE + 8'(NUM_CH * 4)) begin
        wr_ok = 1'b1;
      end else if (wa >= OFS_DAMP_BASE && wa < OFS_DAMP_BASE + 8'(NUM_CH * 4)) begin
        wr_ok = 1'b1;
      end else if (wa == OFS_CHAN_CFG || wa == OFS_ALARM_CFG || wa == OFS_SWRST) begin
        wr_ok = 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= 2'b00;
    end else if (wr_fire) begin
      S_AXI_BVALID_O <= 1'b1;
      S_AXI_BRESP_O <= wr_ok ? 2'b00 : 2'b10;
    end else if (S_AXI_BREADY_I) begin
      S_AXI_BVALID_O <= 1'b0;
    end
  end

  assign soft_rst = wr_fire && (wa == OFS_SWRST) && w_strb_q[0] &&
                    w_data_q[SWRST_LOWER] && w_data_q[SWRST_UPPER];
  assign cfg_rst = SYS_RST_I || soft_rst;

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge CORE_CLK_I) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (cfg_rst) begin
        range_q[c] <= RANGE_RST;
        damp_q[c] <= DAMP_RST;
      end else if (wr_fire && w_strb_q[0]) begin
        if (wa == OFS_RANGE_BASE + 8'(c * 4)) begin
          range_q[c] <= w_data_q[7:0];
        end
        if (wa == OFS_DAMP_BASE + 8'(c * 4)) begin
          damp_q[c] <= w_data_q[DAMP_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (cfg_rst) begin
      shdn_q <= SHDN_RST;
      acfg_q <= ACFG_RST;
    end else if (wr_fire && w_strb_q[0]) begin
      if (wa == OFS_CHAN_CFG) begin
        shdn_q <= w_data_q[NUM_CH-1:0];
      end
      if (wa == OFS_ALARM_CFG) begin
        acfg_q <= w_data_q[4:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel decode
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    docf_chan_decode #(.CH(g)) u_dec (
      .range_i(range_q[g]),
      .damp_i(damp_q[g]),
      .dec_o(dec[g]),
      .damp_ok_o(damp_ok[g])
    );
    assign mode_ok[g] = dec[g].valid;
    assign image[g*8 +: 8] = range_q[g];
  end
  assign image[63:48] = {2'b00, shdn_q, 3'b000, acfg_q};

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      CHAN_SHUTDOWN_O <= SHDN_RST;
      CHAN_FS_MA_O <= '0;
      CHAN_DAMP_O <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        CHAN_SHUTDOWN_O[c] <= shdn_q[c] || therm_sd_q;
        CHAN_FS_MA_O[c*11 +: 11] <= mode_ok[c] ? dec[c].fs_ma : 11'h000;
        CHAN_DAMP_O[c*DAMP_W +: DAMP_W] <= damp_q[c];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Background CRC
  docf_crc_scan u_crc (
    .clk_i(CORE_CLK_I),
    .rst_i(cfg_rst),
    .image_i(image),
    .reload_i(wr_fire && wr_ok && wa != OFS_SWRST),
    .fail_o(crc_fail)
  );

  ////////////////////////////////////////////////////////////////////////
  // Temperature and fault flags
  assign tw_hot = DIE_TEMP_I >= TEMP_WARN_C;
  assign ot_hot = DIE_TEMP_I >= TEMP_OVER_C;
  assign cool = DIE_TEMP_I < TEMP_CLEAR_C;

  always_ff @(posedge CORE_CLK_I) begin
    if (cfg_rst) begin
      stat_crc_q <= 1'b0;
      therm_sd_q <= 1'b0;
    end else begin
      if (crc_fail) begin
        stat_crc_q <= 1'b1;
      end
      if (ot_hot && acfg_q[ACFG_THERM_SD_EN]) begin
        therm_sd_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (cfg_rst) begin
      stat_tw_q <= 1'b0;
      stat_ot_q <= 1'b0;
    end else begin
      if (tw_hot) begin
        stat_tw_q <= 1'b1;
      end else if (cool) begin
        stat_tw_q <= 1'b0;
      end
      if (ot_hot) begin
        stat_ot_q <= 1'b1;
      end else if (cool) begin
        stat_ot_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (cfg_rst) begin
      tw_prev_q <= 1'b0;
      ot_prev_q <= 1'b0;
    end else begin
      tw_prev_q <= tw_hot;
      ot_prev_q <= ot_hot;
    end
  end

  // Latched events, set wins over read
  always_ff @(posedge CORE_CLK_I) begin
    if (cfg_rst) begin
      pend_crc_q <= 1'b0;
      pend_tw_q <= 1'b0;
      pend_ot_q <= 1'b0;
    end else begin
      if (crc_fail) begin
        pend_crc_q <= 1'b1;
      end else if (status_read) begin
        pend_crc_q <= 1'b0;
      end
      if (tw_hot && !tw_prev_q) begin
        pend_tw_q <= 1'b1;
      end else if (status_read) begin
        pend_tw_q <= 1'b0;
      end
      if (ot_hot && !ot_prev_q) begin
        pend_ot_q <= 1'b1;
      end else if (status_read) begin
        pend_ot_q <= 1'b0;
      end
    end
  end

  assign alarm_n_d = !((pend_crc_q && !acfg_q[ACFG_CRC_MASK]) ||
                       (pend_tw_q && !acfg_q[ACFG_TW_MASK]) ||
                       (pend_ot_q && !acfg_q[ACFG_OT_MASK]));

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      ALARM_N_O <= 1'b1;
      ALARM_N_OE_N_O <= 1'b0;
    end else begin
      ALARM_N_O <= alarm_n_d;
      // Enable follows the new level, so an active alarm is driven
      ALARM_N_OE_N_O <= acfg_q[ACFG_OPEN_DRAIN] && alarm_n_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;
  assign rd_fire = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  assign status_read = rd_fire && S_AXI_ARADDR_I == OFS_STATUS;

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (S_AXI_ARADDR_I[1:0] != 2'b00) begin
      rd_ok = 1'b0;
    end else if (S_AXI_ARADDR_I < OFS_RANGE_BASE + 8'(NUM_CH * 4)) begin
      rd_val = {24'h000000, range_q[S_AXI_ARADDR_I[4:2]]};
    end else if (S_AXI_ARADDR_I >= OFS_DAMP_BASE && S_AXI_ARADDR_I < OFS_DAMP_BASE + 8'(NUM_CH * 4)) begin
      rd_val = {28'h0000000, damp_q[S_AXI_ARADDR_I[4:2]]};
    end else begin
      case (S_AXI_ARADDR_I)
        OFS_CHAN_CFG: rd_val = {26'h0000000, shdn_q};
        OFS_ALARM_CFG: rd_val = {27'h0000000, acfg_q};
        OFS_STATUS: rd_val = {28'h0000000, therm_sd_q, stat_ot_q, stat_tw_q, stat_crc_q};
        OFS_SWRST: rd_val = 32'h0000_0000;
        OFS_TEMP: rd_val = {24'h000000, DIE_TEMP_I};
        OFS_CHAN_STATE: rd_val = {20'h00000, damp_ok, mode_ok};
        default: rd_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h0000_0000;
      S_AXI_RRESP_O <= 2'b00;
    end else if (rd_fire) begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RDATA_O <= rd_val;
      S_AXI_RRESP_O <= rd_ok ? 2'b00 : 2'b10;
    end else if (S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
    end
  end
endmodule
`default_nettype wire
